//--- rtl/clc_top.sv
// top: i2c slave, register bank and light sequencing of the flash driver
//
// Functional notes
// [R1] respond only to fixed 7-bit address 0110111, direction bit eighth
// [R2] acknowledge a matching address and serve it; ignore others
// [R3] direction one reads, direction zero writes
// [R4] master sends register address second, msb first, upper three bits zero
// [R5] accept data bytes msb first and acknowledge each one
// [R6] burst write increments the five-bit address counter after each byte
// [R7] write counter wraps to zero after address 0bh
// [R8] sequential read increments counter and wraps to zero after 04h
// [R9] random read: write register address, repeated start, then read
// [R10] after read address ack return one byte then advance counter
// [R11] no ack plus stop from master ends data driving
// [R12] data line changes only while clock low, except start and stop
// [R13] master never writes addresses 07h and above
// [R14] host waits 5 ms after supply before writing the enable pair
// [R15] host waits 5 ms after enable pair before torch request
// [R16] torch bit rise gives torch current within 300 us; clear drops it
// [R17] strobe pin rise or flash bit rise starts the duration timer
// [R18] flash current follows trigger within 500 us even during torch
// [R19] level mode: flash stops at trigger removal or timer expiry
// [R20] level mode: trigger fall clears the duration timer
// [R21] edge mode: flash ends at expiry even with trigger held
// [R22] edge mode: timer clears itself on expiry
// [R23] after flash with torch bit still set, return to torch current
// [R24] writes other than to the key register need the unlock pattern
// [R25] method bit zero selects level, one selects edge control
// [R26] enable pair 00 powers down, 11 drives; mixed values prohibited
// [R27] four-bit duration field selects 5 ms to 800 ms
`timescale 1ns/10ps
module clc_top import clc_pkg::*; #(
  parameter int MS_CYCLES = TICK_CYCLES  // clock cycles per millisecond tick
) (
  input wire logic clk,  // 40 mhz system clock
  input wire logic arst_n,  // asynchronous reset, active low
  input wire logic scl_i,  // i2c clock pin level
  input wire logic sda_i,  // i2c data pin level
  output logic sda_o,  // i2c data output value, always low
  output logic sda_oe_n,  // low while pulling the data line low
  input wire logic strobe_i,  // flash trigger pin
  input wire logic [7:0] fault_i,  // fault flags from analog protection
  output logic drive_on,  // enable pair is 11
  output logic torch_on,  // torch current requested
  output logic flash_on,  // flash current requested
  output logic [2:0] torch_level,  // torch current code
  output logic [2:0] flash_level,  // flash current code
  output logic torch_div5,  // low torch divide
  output logic headroom_sel,  // current source headroom select
  output logic therm_sel,  // thermal recovery select
  output logic [7:0] supply_cfg  // supply detect, override mode, limit
);

  // duration table in milliseconds
  function automatic logic [DUR_W-1:0] dur_ms(input logic [3:0] code);
    case (code)
      4'h0: dur_ms = 10'd5;
      4'h1: dur_ms = 10'd10;
      4'h2: dur_ms = 10'd20;
      4'h3: dur_ms = 10'd30;
      4'h4: dur_ms = 10'd40;
      4'h5: dur_ms = 10'd50;
      4'h6: dur_ms = 10'd70;
      4'h7: dur_ms = 10'd90;
      4'h8: dur_ms = 10'd120;
      4'h9: dur_ms = 10'd150;
      4'ha: dur_ms = 10'd200;
      4'hb: dur_ms = 10'd250;
      4'hc: dur_ms = 10'd300;
      4'hd: dur_ms = 10'd400;
      4'he: dur_ms = 10'd600;
      default: dur_ms = 10'd800;
    endcase
  endfunction

  // address counter step with wrap past the given top
  function automatic logic [4:0] step_addr(input logic [4:0] a, input logic [4:0] top);
    step_addr = (a >= top) ? ADDR_ZERO : a + 5'h01;
  endfunction

  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, stb_m, stb_s, stb_d;
  logic [7:0] flt_m, flt_s;
  logic start_det, stop_det, scl_rise, scl_fall;
  clc_state_t st;
  logic [3:0] bitcnt;
  logic [7:0] shreg, txbyte, rd_byte, next_rd;
  logic rw, mack_n, wr_en;
  logic [4:0] addr, wr_addr;
  logic [7:0] wr_data, key, en_reg, tim_reg, lvl_reg, sup_reg, lit_reg;
  logic flash_d, flash_active, tick, expire, enabled;
  logic [TICK_W-1:0] ms_cnt;
  logic [DUR_W-1:0] tmr_ms;

  // two-stage synchronisers plus one delay stage for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {stb_m, stb_s, stb_d} <= 3'h0;
      flt_m <= 8'h00;
      flt_s <= 8'h00;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
      {stb_m, stb_s, stb_d} <= {strobe_i, stb_m, stb_s};
      flt_m <= fault_i;
      flt_s <= flt_m;
    end
  end

  // bus conditions
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign enabled = (en_reg[EN_HI_BIT:EN_LO_BIT] == EN_BOTH);  // R26

  // read data mux; unimplemented addresses read zero
  always_comb begin
    case (addr)
      OFS_KEY: rd_byte = key;
      OFS_ENABLE: rd_byte = en_reg;
      OFS_TIMING: rd_byte = tim_reg;
      OFS_LEVEL: rd_byte = lvl_reg;
      OFS_SUPPLY: rd_byte = sup_reg;
      OFS_LIGHT: rd_byte = lit_reg;
      OFS_FAULT: rd_byte = flt_s;
      default: rd_byte = 8'h00;
    endcase
    next_rd = rd_byte;
  end

  // i2c protocol engine; data line moves on scl fall, and is released at start or stop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= S_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txbyte <= 8'h00;
      rw <= 1'b0;
      mack_n <= 1'b1;
      addr <= ADDR_ZERO;
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= ADDR_ZERO;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start_det) begin
        st <= S_DEVADR;
        bitcnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_det) begin
        st <= S_IDLE;  // R11
        sda_oe_n <= 1'b1;  // R11
      end else if (scl_rise) begin
        if (st == S_DEVADR || st == S_REGADR || st == S_WDATA) begin
          shreg <= {shreg[6:0], sda_s};  // R5
          bitcnt <= bitcnt + 4'h1;
        end
        if (st == S_MACK) begin
          mack_n <= sda_s;
        end
      end else if (scl_fall) begin
        case (st)
          S_DEVADR: begin
            if (bitcnt == BITS_PER_BYTE) begin
              if (shreg[7:1] == SLAVE_ADDR) begin  // R1
                st <= S_DEVACK;
                rw <= shreg[0];  // R3
                sda_oe_n <= 1'b0;  // R2
              end else begin
                st <= S_IDLE;  // R2
              end
            end
          end
          S_DEVACK: begin
            bitcnt <= 4'h0;
            if (rw) begin
              st <= S_RDATA;  // R3
              txbyte <= next_rd;  // R10
              sda_oe_n <= next_rd[7];
              addr <= step_addr(addr, RD_TOP_ADDR);  // R10 R8
            end else begin
              st <= S_REGADR;
              sda_oe_n <= 1'b1;
            end
          end
          S_REGADR: begin
            if (bitcnt == BITS_PER_BYTE) begin
              st <= S_REGACK;
              sda_oe_n <= 1'b0;  // R5
            end
          end
          S_REGACK: begin
            st <= S_WDATA;
            bitcnt <= 4'h0;
            addr <= shreg[4:0];  // R9
            sda_oe_n <= 1'b1;
          end
          S_WDATA: begin
            if (bitcnt == BITS_PER_BYTE) begin
              st <= S_WACK;
              sda_oe_n <= 1'b0;  // R5
              wr_en <= 1'b1;
              wr_addr <= addr;
              wr_data <= shreg;
              addr <= step_addr(addr, WR_TOP_ADDR);  // R6 R7
            end
          end
          S_WACK: begin
            st <= S_WDATA;
            bitcnt <= 4'h0;
            sda_oe_n <= 1'b1;
          end
          S_RDATA: begin
            if (bitcnt == LAST_TX_BIT) begin
              st <= S_MACK;
              sda_oe_n <= 1'b1;  // R12
            end else begin
              bitcnt <= bitcnt + 4'h1;
              txbyte <= {txbyte[6:0], 1'b0};
              sda_oe_n <= txbyte[6];  // R12
            end
          end
          S_MACK: begin
            bitcnt <= 4'h0;
            if (!mack_n) begin
              st <= S_RDATA;
              txbyte <= next_rd;
              sda_oe_n <= next_rd[7];
              addr <= step_addr(addr, RD_TOP_ADDR);  // R8
            end else begin
              st <= S_IDLE;  // R11
            end
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end

  // register bank; everything but the key needs the unlock pattern
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key <= RST_KEY;
      en_reg <= RST_ENABLE;
      tim_reg <= RST_TIMING;
      lvl_reg <= RST_LEVEL;
      sup_reg <= RST_SUPPLY;
      lit_reg <= RST_LIGHT;
    end else if (wr_en) begin
      if (wr_addr == OFS_KEY) begin
        key <= wr_data;
      end else if (key == UNLOCK_PATTERN) begin  // R24
        case (wr_addr)
          OFS_ENABLE: en_reg <= wr_data & MSK_ENABLE;
          OFS_TIMING: tim_reg <= wr_data & MSK_TIMING;
          OFS_LEVEL: lvl_reg <= wr_data & MSK_LEVEL;
          OFS_SUPPLY: sup_reg <= wr_data & MSK_SUPPLY;
          OFS_LIGHT: lit_reg <= wr_data & MSK_LIGHT;
          default: ;
        endcase
      end
    end
  end

  // millisecond tick, only running during a flash
  assign tick = (ms_cnt == TICK_W'(MS_CYCLES - 1));
  assign expire = tick && ((tmr_ms + 10'd1) >= dur_ms(tim_reg[3:0]));  // R27
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt <= '0;
    end else if (!flash_active || tick) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_cnt + TICK_W'(1);
    end
  end

  // flash sequencing: triggers, level/edge method and duration timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_d <= 1'b0;
      flash_active <= 1'b0;
      tmr_ms <= '0;
    end else begin
      flash_d <= lit_reg[FLASH_BIT];
      if (!enabled) begin  // R26
        flash_active <= 1'b0;
        tmr_ms <= '0;
      end else if ((stb_s && !stb_d) || (lit_reg[FLASH_BIT] && !flash_d)) begin
        flash_active <= 1'b1;  // R17 R18
        tmr_ms <= '0;
      end else if (!tim_reg[EDGE_BIT] && ((!stb_s && stb_d) ||
                   (!lit_reg[FLASH_BIT] && flash_d))) begin  // R25
        flash_active <= 1'b0;  // R19
        tmr_ms <= '0;  // R20
      end else if (flash_active && expire) begin
        flash_active <= 1'b0;  // R19 R21
        tmr_ms <= '0;  // R22
      end else if (flash_active && tick) begin
        tmr_ms <= tmr_ms + 10'd1;
      end
    end
  end

  // light outputs; torch resumes after a flash while requested
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_on <= 1'b0;
      torch_on <= 1'b0;
      flash_on <= 1'b0;
      torch_level <= 3'h0;
      flash_level <= 3'h0;
      torch_div5 <= 1'b0;
      headroom_sel <= 1'b0;
      therm_sel <= 1'b0;
      supply_cfg <= 8'h00;
    end else begin
      drive_on <= enabled;  // R26
      torch_on <= enabled && lit_reg[TORCH_BIT] && !flash_active;  // R16 R23
      flash_on <= flash_active;  // R18
      torch_level <= lvl_reg[5:3];
      flash_level <= lvl_reg[2:0];
      torch_div5 <= lvl_reg[DIV5_BIT];
      headroom_sel <= tim_reg[HEADROOM_BIT];
      therm_sel <= tim_reg[THERM_SEL_BIT];
      supply_cfg <= sup_reg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_addr_match;
    (st == S_DEVACK) |-> (shreg[7:1] == SLAVE_ADDR);
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("ack on foreign address"); // R1
  property p_ack_drive;
    (st == S_DEVACK) || (st == S_WACK) || (st == S_REGACK) |-> !sda_oe_n;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack slot not driven low"); // R2
  property p_wr_wrap;
    (scl_fall && st == S_WDATA && bitcnt == BITS_PER_BYTE && !start_det && !stop_det) |=>
      addr == (($past(addr) >= WR_TOP_ADDR) ? ADDR_ZERO : $past(addr) + 5'h01);
  endproperty
  a_wr_wrap: assert property (p_wr_wrap) else $error("write counter step wrong"); // R7
  property p_rd_wrap;
    $rose(st == S_RDATA) |->
      addr == (($past(addr) >= RD_TOP_ADDR) ? ADDR_ZERO : $past(addr) + 5'h01);
  endproperty
  a_rd_wrap: assert property (p_rd_wrap) else $error("read counter step wrong"); // R8
  property p_stop_release;
    stop_det |=> sda_oe_n && (st == S_IDLE);
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("data held after stop"); // R11
  property p_scl_low_change;
    $changed(sda_oe_n) |-> !scl_s || $past(start_det || stop_det);
  endproperty
  a_scl_low_change: assert property (p_scl_low_change) else $error("sda moved, scl high"); // R12
  property p_torch;
    enabled && lit_reg[TORCH_BIT] && !flash_active ##1 !flash_active |-> torch_on;
  endproperty
  a_torch: assert property (p_torch) else $error("torch not on"); // R16
  property p_trigger;
    enabled && stb_s && !stb_d |=> flash_active ##1 flash_on;
  endproperty
  a_trigger: assert property (p_trigger) else $error("strobe did not start flash"); // R17
  property p_level_fall;
    enabled && !tim_reg[EDGE_BIT] && !stb_s && stb_d && !lit_reg[FLASH_BIT] && !flash_d
      |=> !flash_active && tmr_ms == '0;
  endproperty
  a_level_fall: assert property (p_level_fall) else $error("level flash not ended"); // R20
  property p_expire;
    flash_active && expire && !(stb_s && !stb_d) && !(lit_reg[FLASH_BIT] && !flash_d)
      |=> !flash_active && tmr_ms == '0;
  endproperty
  a_expire: assert property (p_expire) else $error("flash outlived timer"); // R21
  property p_locked;
    wr_en && wr_addr != OFS_KEY && key != UNLOCK_PATTERN |=>
      $stable({en_reg, tim_reg, lvl_reg, sup_reg, lit_reg});
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took effect"); // R24
  c_write: cover property (wr_en && wr_addr == OFS_LIGHT);
  c_read: cover property (st == S_MACK ##1 st == S_RDATA);
  c_flash_end: cover property (flash_active && expire);
endmodule

//--- rtl/clc_pkg.sv
// package: constants for the camera light i2c control block
package clc_pkg;
  // i2c slave identity and address counter limits
  localparam logic [6:0] SLAVE_ADDR = 7'h37;
  localparam logic [7:0] UNLOCK_PATTERN = 8'h69;
  localparam logic [4:0] WR_TOP_ADDR = 5'h0b;
  localparam logic [4:0] RD_TOP_ADDR = 5'h04;
  localparam logic [4:0] ADDR_ZERO = 5'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  // register offsets
  localparam logic [4:0] OFS_KEY = 5'h00;
  localparam logic [4:0] OFS_ENABLE = 5'h01;
  localparam logic [4:0] OFS_TIMING = 5'h02;
  localparam logic [4:0] OFS_LEVEL = 5'h03;
  localparam logic [4:0] OFS_SUPPLY = 5'h04;
  localparam logic [4:0] OFS_LIGHT = 5'h05;
  localparam logic [4:0] OFS_FAULT = 5'h06;
  // reset values
  localparam logic [7:0] RST_KEY = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h07;
  localparam logic [7:0] RST_LEVEL = 8'h0c;
  localparam logic [7:0] RST_SUPPLY = 8'h02;
  localparam logic [7:0] RST_LIGHT = 8'h00;
  // writable bit masks
  localparam logic [7:0] MSK_ENABLE = 8'h03;
  localparam logic [7:0] MSK_TIMING = 8'h7f;
  localparam logic [7:0] MSK_LEVEL = 8'h7f;
  localparam logic [7:0] MSK_SUPPLY = 8'h73;
  localparam logic [7:0] MSK_LIGHT = 8'h03;
  // field positions
  localparam int EN_LO_BIT = 0;
  localparam int EN_HI_BIT = 1;
  localparam int EDGE_BIT = 4;
  localparam int HEADROOM_BIT = 5;
  localparam int THERM_SEL_BIT = 6;
  localparam int DIV5_BIT = 6;
  localparam int TORCH_BIT = 0;
  localparam int FLASH_BIT = 1;
  localparam logic [1:0] EN_BOTH = 2'h3;
  // timing: clock rate and the millisecond tick of the flash timer
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 16;
  localparam int DUR_W = 10;
  // one-hot i2c states
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_DEVADR = 9'h002,
    S_DEVACK = 9'h004,
    S_REGADR = 9'h008,
    S_REGACK = 9'h010,
    S_WDATA = 9'h020,
    S_WACK = 9'h040,
    S_RDATA = 9'h080,
    S_MACK = 9'h100
  } clc_state_t;
endpackage

//--- bench/clc_i2c_master.sv
// i2c bus master model that drives the device pins
`timescale 1ns/10ps
module clc_i2c_master #(
  parameter int QTR = 15  // clock cycles per quarter of a bit
) (
  input wire logic clk,  // system clock
  input wire logic sda_wire,  // resolved data line level
  output logic scl,  // serial clock, idle high
  output logic sda_rel  // high releases the data line to the pull-up
);
  // bus idles released
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // quarter bit delay
  task automatic q();
    repeat (QTR) @(posedge clk);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_rel <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_rel <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_rel <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_rel <= 1'b1;
    q();
  endtask
  // data changes only with the clock low
  task automatic bit_out(input logic b);
    sda_rel <= b;
    q();
    scl <= 1'b1;
    q();
    q();
    scl <= 1'b0;
    q();
  endtask
  // release the line and sample it mid high phase
  task automatic bit_in(output logic b);
    sda_rel <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    b = sda_wire;
    q();
    scl <= 1'b0;
    q();
  endtask
  // byte out msb first, returns the acknowledge slot level
  task automatic wbyte(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(nack);
  endtask
  // byte in msb first, last byte left unacknowledged
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_in(b);
      d[i] = b;
    end
    bit_out(last);
  endtask
endmodule

//--- bench/clc_top_tb_top.sv
// self-checking bench for the camera light i2c control block
`timescale 1ns/10ps
module clc_top_tb_top import clc_pkg::*; ;
  typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} clc_row_t;
  localparam int MS = 4;
  localparam int LIMIT = 90000;
  logic clk, arst_n, strobe_i, sda_o, sda_oe_n, scl, sda_rel, sda_wire;
  logic drive_on, torch_on, flash_on, torch_div5, headroom_sel, therm_sel;
  logic [7:0] fault_i, supply_cfg;
  logic [2:0] torch_level, flash_level;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] rst_exp [6] = '{8'h00, 8'h00, 8'h07, 8'h0c, 8'h02, 8'h00};
  logic [7:0] burst [5] = '{8'h11, 8'h22, 8'h69, 8'h03, 8'h00};
  clc_row_t rows [6] = '{'{5'h01, 8'hff, 8'h03}, '{5'h02, 8'hff, 8'h7f},
    '{5'h03, 8'h6b, 8'h6b}, '{5'h04, 8'hff, 8'h73}, '{5'h06, 8'h00, 8'ha5},
    '{5'h05, 8'hfc, 8'h00}};
  // open-drain data line with pull-up
  assign sda_wire = sda_rel & (sda_oe_n | sda_o);
  clc_i2c_master m (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_rel(sda_rel));
  clc_top #(.MS_CYCLES(MS)) DUT (.clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_wire),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .strobe_i(strobe_i), .fault_i(fault_i),
    .drive_on(drive_on), .torch_on(torch_on), .flash_on(flash_on),
    .torch_level(torch_level), .flash_level(flash_level), .torch_div5(torch_div5),
    .headroom_sel(headroom_sel), .therm_sel(therm_sel), .supply_cfg(supply_cfg));
  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("Error %0t: timeout", $time);
      results();
    end
  end
  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rng(input int c, input int lo, input int hi, input string what);
    compares++;
    if (c < lo || c > hi) begin
      error_cnt++;
      $display("Error %0t: %s took %0d cycles, not %0d..%0d", $time, what, c, lo, hi);
    end
  endtask
  // settle after an edge before looking at outputs
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // count cycles until flash output reaches a level
  task automatic wfl(input logic v, input int n, output int c);
    c = 0;
    while (flash_on !== v && c < n) begin
      tick(1);
      c++;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic n0, n1, n2;
    m.start();
    m.wbyte(8'h6e, n0);
    m.wbyte({3'h0, a}, n1);
    m.wbyte(d, n2);
    m.stop();
    chk({5'h0, n0, n1, n2}, 8'h00, "write acks");
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    logic n0, n1, n2;
    m.start();
    m.wbyte(8'h6e, n0);
    m.wbyte({3'h0, a}, n1);
    m.start();
    m.wbyte(8'h6f, n2);
    m.rbyte(1'b1, d);
    m.stop();
    tick(5);
    chk({5'h0, n0, n1, n2}, 8'h00, "read acks");
    chk({7'h0, sda_oe_n}, 8'h01, "released after stop");
  endtask
  // main sequence
  initial begin
    logic [7:0] d;
    logic n;
    int c;
    arst_n = 1'b0;
    strobe_i = 1'b0;
    fault_i = 8'ha5;
    tick(1);
    chk({7'h0, sda_oe_n}, 8'h01, "data released in reset");
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    tick(5);
    chk({2'h0, torch_level, flash_level}, 8'h0c, "config outputs after reset");
    // reset values by sequential read, counter wraps after 04h
    m.start();
    m.wbyte(8'h6e, n);
    m.wbyte(8'h00, n);
    m.start();
    m.wbyte(8'h6f, n);
    for (int i = 0; i < 6; i++) begin
      m.rbyte(i == 5, d);
      chk(d, rst_exp[i], "reset value");
    end
    m.stop();
    rd(5'h02, d);
    chk(d, 8'h07, "random read");
    m.start();
    m.wbyte(8'h6f, n);
    m.rbyte(1'b1, d);
    m.stop();
    chk(d, 8'h0c, "counter advanced after read");
    $display("test reset and read done");
    m.start();
    m.wbyte(8'h6c, n);
    m.stop();
    chk({7'h0, n}, 8'h01, "foreign address acked");
    wr(5'h03, 8'h55);
    rd(5'h03, d);
    chk(d, 8'h0c, "locked write took effect");
    $display("test address and lock done");
    // burst from 0ah wraps to 00h and unlocks on the way
    m.start();
    m.wbyte(8'h6e, n);
    m.wbyte(8'h0a, n);
    for (int i = 0; i < 5; i++) begin
      m.wbyte(burst[i], n);
      chk({7'h0, n}, 8'h00, "burst ack");
    end
    m.stop();
    rd(5'h01, d);
    chk(d, 8'h03, "burst wrap reg 1");
    chk({7'h0, drive_on}, 8'h01, "drive on");
    $display("test burst done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d);
      chk(d, rows[i].e, "register readback");
    end
    chk({torch_div5, torch_level, 1'b0, flash_level}, 8'hd3, "level outputs");
    chk({6'h0, headroom_sel, therm_sel}, 8'h03, "config outputs");
    chk(supply_cfg, 8'h73, "supply output");
    $display("test register rows done");
    // level mode, 5 ms limit
    wr(5'h02, 8'h00);
    wr(5'h05, 8'h01);
    tick(3);
    chk({7'h0, torch_on}, 8'h01, "torch on");
    strobe_i <= 1'b1;
    wfl(1'b1, 10, c);
    rng(c, 0, 6, "flash start");
    tick(8);
    strobe_i <= 1'b0;
    wfl(1'b0, 10, c);
    rng(c, 0, 6, "flash end at trigger fall");
    tick(4);
    chk({7'h0, torch_on}, 8'h01, "torch back");
    strobe_i <= 1'b1;
    wfl(1'b1, 10, c);
    wfl(1'b0, 100, c);
    rng(c, 4 * MS, 5 * MS + 4, "level flash limit");
    strobe_i <= 1'b0;
    $display("test level flash done");
    // edge mode, 10 ms limit, trigger held
    wr(5'h02, 8'h11);
    for (int k = 0; k < 2; k++) begin
      tick(5);
      strobe_i <= 1'b1;
      wfl(1'b1, 10, c);
      wfl(1'b0, 100, c);
      rng(c, 9 * MS, 10 * MS + 4, "edge flash limit");
      tick(5);
      chk({7'h0, flash_on}, 8'h00, "held trigger no flash");
      strobe_i <= 1'b0;
    end
    // flash from the request bit, 50 ms
    wr(5'h02, 8'h15);
    wr(5'h05, 8'h03);
    tick(1);
    chk({7'h0, flash_on}, 8'h01, "flash bit");
    wfl(1'b0, 300, c);
    tick(3);
    chk({6'h0, flash_on, torch_on}, 8'h01, "torch after flash");
    wr(5'h05, 8'h00);
    tick(3);
    chk({7'h0, torch_on}, 8'h00, "torch off");
    wr(5'h01, 8'h02);
    tick(3);
    chk({7'h0, drive_on}, 8'h00, "mixed pair off");
    $display("test edge and light done");
    // mid-run reset returns the bank to its defaults and locks it again
    arst_n <= 1'b0;
    tick(2);
    chk({7'h0, sda_oe_n}, 8'h01, "data released in mid-run reset");
    chk({2'h0, torch_level, flash_level}, 8'h00, "outputs held in reset");
    arst_n <= 1'b1;
    tick(5);
    chk({2'h0, torch_level, flash_level}, 8'h0c, "config outputs after mid-run reset");
    rd(5'h00, d);
    chk(d, 8'h00, "key cleared by reset");
    wr(5'h05, 8'h01);
    rd(5'h05, d);
    chk(d, 8'h00, "locked after reset");
    $display("test mid-run reset done");
    results();
  end
endmodule
